// ===== hw/memory_space_decode.sv
// address decode, space map, paging and power blocking of the companion chip
// Operation
// R1: host uses fetch strobe for code, read for data
// R2: each memory maps to code, data or both; the sram here always answers data reads, so it maps to data or both
// R3: space map loads initial value, writable anytime
// R4: bit0 fetch to sram, bit7 pio mode
// R5: bit2 fetch, bit4 read reach primary flash
// R6: bit1 fetch, bit3 read reach secondary flash
// R7: value 0ch gives separate spaces
// R8: both bits set answers both strobes
// R9: eight bit page register on data lines
// R10: page register sits at offset e0h
// R11: page bits feed the decode array
// R12: spare page bits feed general array
// R13: eight primary selects, three terms each
// R14: four secondary selects, three terms each
// R15: sram select two terms, config select
// R16: test port select and two peripheral selects
// R17: shared 73 input bus, address control reset
// R18: port d, page, feedback, flash status
// R19: extended mode uses address bits 19..4
// R20: fast bit clear, standby after 70ns idle
// R21: five blocking bits gate control signals; bit 4 is stored here but gates nothing
// R22: three external selects, 137 terms maximum
// R23: secondary sector wins over primary sector
// R24: sram, io, peripheral win over flash
// R25: sram enabled only while its select high
// R26: enable needs select and permitted strobe
`timescale 1ns/1ps
`default_nettype none
module memory_space_decode #(
   parameter int n_in = space_decode_pkg::array_inputs,
   parameter int pterms = space_decode_pkg::sector_terms,
   parameter int rterms = space_decode_pkg::ram_terms,
   parameter int gterms = space_decode_pkg::general_terms_max,
   parameter logic [7:0] space_map_reset = space_decode_pkg::space_map_init
) (
   input wire logic clock,
   input wire logic rstn,
   input wire space_decode_pkg::host_bus_s host_bus,
   input wire logic [7:0] data_in,
   input wire logic reset_input,
   input wire logic power_down_input,
   input wire logic [23:0] input_cell,
   input wire logic [2:0] port_d_in,
   input wire logic [7:0] cell_group1_feedback,
   input wire logic [7:0] cell_group2_feedback,
   input wire logic secondary_busy,
   input wire logic [(space_decode_pkg::primary_sectors+space_decode_pkg::secondary_sectors
      +space_decode_pkg::periph_selects+2)*3*space_decode_pkg::array_inputs-1:0] dec_care,
   input wire logic [(space_decode_pkg::primary_sectors+space_decode_pkg::secondary_sectors
      +space_decode_pkg::periph_selects+2)*3*space_decode_pkg::array_inputs-1:0] dec_value,
   input wire logic [(space_decode_pkg::primary_sectors+space_decode_pkg::secondary_sectors
      +space_decode_pkg::periph_selects+2)*3-1:0] dec_used,
   input wire logic [space_decode_pkg::ext_selects*3*space_decode_pkg::array_inputs-1:0] ecs_care,
   input wire logic [space_decode_pkg::ext_selects*3*space_decode_pkg::array_inputs-1:0] ecs_value,
   input wire logic [space_decode_pkg::ext_selects*3-1:0] ecs_used,
   input wire logic [7:0] general_page_mask,
   output logic [7:0] data_out,
   output logic data_out_valid,
   output space_decode_pkg::selects_s selects,
   output space_decode_pkg::enables_s enables,
   output logic [space_decode_pkg::ext_selects-1:0] ext_chip_sel,
   output logic [7:0] page_bits,
   output logic [7:0] space_map_reg,
   output logic [7:0] general_page_bits,
   output logic array_standby
);
   localparam int n_dec = space_decode_pkg::primary_sectors + space_decode_pkg::secondary_sectors
      + space_decode_pkg::periph_selects + 2;
   localparam int n_ps = space_decode_pkg::primary_sectors;
   localparam int n_ss = space_decode_pkg::secondary_sectors;
   localparam int n_pio = space_decode_pkg::periph_selects;
   localparam int idle_w = $clog2(space_decode_pkg::standby_cycles + 1);
   localparam logic [idle_w-1:0] idle_max = idle_w'(space_decode_pkg::standby_cycles);

   // two-flop synchronisers for every pin-level input
   logic [$bits(space_decode_pkg::host_bus_s)-1:0] bus_meta, bus_sync;
   logic [7:0] data_meta, data_sync;
   logic [1:0] misc_meta, misc_sync;
   logic [23:0] cell_meta, cell_sync;
   logic [2:0] pd_meta, pd_sync;
   logic [16:0] fb_meta, fb_sync;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         bus_meta <= '0;
         bus_sync <= '0;
         data_meta <= '0;
         data_sync <= '0;
         misc_meta <= '0;
         misc_sync <= '0;
         cell_meta <= '0;
         cell_sync <= '0;
         pd_meta <= '0;
         pd_sync <= '0;
         fb_meta <= '0;
         fb_sync <= '0;
      end
      else
      begin
         bus_meta <= host_bus;
         bus_sync <= bus_meta;
         data_meta <= data_in;
         data_sync <= data_meta;
         misc_meta <= {reset_input, power_down_input};
         misc_sync <= misc_meta;
         cell_meta <= input_cell;
         cell_sync <= cell_meta;
         pd_meta <= port_d_in;
         pd_sync <= pd_meta;
         fb_meta <= {secondary_busy, cell_group2_feedback, cell_group1_feedback};
         fb_sync <= fb_meta;
      end
   end
   space_decode_pkg::host_bus_s hb;
   assign hb = bus_sync;

   logic [7:0] power_mode_reg0, power_mode_reg2;
   logic [15:0] arr_addr;
   logic [2:0] arr_ctl;
   logic [n_in-1:0] arr_bus;
   // extended-address host presents a19..a4 to the arrays
   assign arr_addr = hb.ext_addr_mode ? hb.addr[19:4] : hb.addr[15:0]; // R19
   // blocked control signals read as inactive; only safe if unused in equations
   assign arr_ctl = {hb.program_strobe & ~power_mode_reg2[2],
                     hb.bus_control_1 & ~power_mode_reg2[1],
                     hb.write_strobe & ~power_mode_reg2[0]}; // R21
   // R17 R18 R11
   assign arr_bus = {fb_sync[16], fb_sync[15:8], fb_sync[7:0], page_bits, pd_sync, cell_sync,
                     misc_sync[0], misc_sync[1] & ~power_mode_reg2[3], arr_ctl, arr_addr};

   // config block select: fixed high address byte compare, not one of the decode array outputs
   logic [n_dec-1:0] dec_hit;
   logic [space_decode_pkg::ext_selects-1:0] ecs_hit;
   genvar g;
   generate
      for (g = 0; g < n_dec; g++)
      begin : g_dec
         product_term_or #(.inputs(n_in), .terms(pterms)) u_term (
            .bus(arr_bus),
            .care(dec_care[g*pterms*n_in +: pterms*n_in]),
            .value(dec_value[g*pterms*n_in +: pterms*n_in]),
            // sram select keeps only two of its three terms
            .term_used((g == n_ps+n_ss) ?
               (dec_used[g*pterms +: pterms] & pterms'((1 << rterms) - 1))
               : dec_used[g*pterms +: pterms]),
            .hit(dec_hit[g])
         ); // R13 R14 R15 R16
      end
      for (g = 0; g < space_decode_pkg::ext_selects; g++)
      begin : g_ecs
         product_term_or #(.inputs(n_in), .terms(pterms)) u_term (
            .bus(arr_bus),
            .care(ecs_care[g*pterms*n_in +: pterms*n_in]),
            .value(ecs_value[g*pterms*n_in +: pterms*n_in]),
            .term_used(ecs_used[g*pterms +: pterms]),
            .hit(ecs_hit[g])
         ); // R22
      end
   endgenerate
   // one register for all selects keeps a single driver on the port
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         ext_chip_sel <= '0;
      else
         ext_chip_sel <= ecs_hit; // R22
   end

   logic [n_ps-1:0] ps_raw;
   logic [n_ss-1:0] ss_raw;
   logic ram_raw, cfg_raw, test_raw;
   logic [n_pio-1:0] pio_raw;
   logic wins_flash, ss_any;
   assign ps_raw = dec_hit[n_ps-1:0];
   assign ss_raw = dec_hit[n_ps+n_ss-1:n_ps];
   assign ram_raw = dec_hit[n_ps+n_ss];
   assign test_raw = dec_hit[n_ps+n_ss+1];
   assign pio_raw = dec_hit[n_dec-1:n_ps+n_ss+2] & {n_pio{space_map_reg[space_decode_pkg::map_pio_enable]}}; // R4
   // config space decoded on high address byte with no bus control blocked
   localparam logic [7:0] cfg_base = 8'h00_FF;
   assign cfg_raw = (arr_addr[15:8] == cfg_base);
   assign wins_flash = ram_raw | cfg_raw | (|pio_raw); // R24
   assign ss_any = |ss_raw & ~wins_flash;

   space_decode_pkg::selects_s next_selects;
   always_comb
   begin
      next_selects.ram_select = ram_raw;
      next_selects.config_reg_select = cfg_raw & ~ram_raw;
      next_selects.periph_select = pio_raw & {n_pio{~ram_raw & ~cfg_raw}};
      next_selects.test_port_select = test_raw;
      next_selects.secondary_sector_sel = ss_raw & {n_ss{~wins_flash}}; // R24
      next_selects.primary_sector_sel = ps_raw & {n_ps{~wins_flash & ~ss_any}}; // R23
   end

   // code and data strobes, each gated by its map bit except sram and config reads
   logic fetch, rd;
   assign fetch = hb.program_strobe;
   assign rd = hb.bus_control_1;
   space_decode_pkg::enables_s next_enables;
   logic p_ok, s_ok, r_ok;
   // R2 R5 R6 R7 R8
   assign p_ok = (fetch & space_map_reg[space_decode_pkg::map_primary_code])
               | (rd & space_map_reg[space_decode_pkg::map_primary_data]);
   assign s_ok = (fetch & space_map_reg[space_decode_pkg::map_secondary_code])
               | (rd & space_map_reg[space_decode_pkg::map_secondary_data]);
   // sram always answers data reads; fetches only with its code bit
   assign r_ok = (fetch & space_map_reg[space_decode_pkg::map_sram_code]) | rd; // R4
   always_comb
   begin
      next_enables.primary_oe = next_selects.primary_sector_sel & {n_ps{p_ok}}; // R26
      next_enables.secondary_oe = next_selects.secondary_sector_sel & {n_ss{s_ok}}; // R26
      next_enables.ram_oe = next_selects.ram_select & r_ok; // R25
      next_enables.config_oe = next_selects.config_reg_select & rd;
      next_enables.periph_oe = next_selects.periph_select & {n_pio{rd}};
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         selects <= '0;
         enables <= '0;
      end
      else
      begin
         selects <= next_selects;
         enables <= next_enables;
      end
   end

   // config register writes on write strobe rising edge
   logic wr_q, wr_rise, rd_q, rd_rise;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end
      else
      begin
         wr_q <= hb.write_strobe;
         rd_q <= rd;
      end
   end
   assign wr_rise = hb.write_strobe & ~wr_q;
   assign rd_rise = rd & ~rd_q;
   logic cfg_wr;
   assign cfg_wr = wr_rise & cfg_raw;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         page_bits <= space_decode_pkg::page_init;
      else if (cfg_wr && arr_addr[7:0] == space_decode_pkg::page_offset)
         page_bits <= data_sync; // R9 R10
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         space_map_reg <= space_map_reset; // R3
      else if (cfg_wr && arr_addr[7:0] == space_decode_pkg::space_map_offset)
         space_map_reg <= data_sync & 8'h00_9F; // R3 R4
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         power_mode_reg0 <= space_decode_pkg::power_mode0_init;
         power_mode_reg2 <= space_decode_pkg::power_mode2_init;
      end
      else if (cfg_wr)
      begin
         if (arr_addr[7:0] == space_decode_pkg::power_mode0_offset)
            power_mode_reg0 <= data_sync;
         if (arr_addr[7:0] == space_decode_pkg::power_mode2_offset)
            power_mode_reg2 <= data_sync & 8'h00_1F; // R21
      end
   end

   // register read-back; unmapped config offsets read as zero
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         data_out <= '0;
         data_out_valid <= 1'b0;
      end
      else
      begin
         data_out_valid <= rd & cfg_raw;
         if (rd_rise && cfg_raw)
         begin
            unique case (arr_addr[7:0])
               space_decode_pkg::page_offset: data_out <= page_bits; // R9
               space_decode_pkg::space_map_offset: data_out <= space_map_reg;
               space_decode_pkg::power_mode0_offset: data_out <= power_mode_reg0;
               space_decode_pkg::power_mode2_offset: data_out <= power_mode_reg2;
               default: data_out <= '0;
            endcase
         end
      end
   end

   // spare page bits offered to the general array
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         general_page_bits <= '0;
      else
         general_page_bits <= page_bits & general_page_mask; // R12
   end

   // standby after the array inputs sit still; fast mode keeps it awake
   logic [n_in-1:0] bus_q;
   logic [idle_w-1:0] idle_count;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         bus_q <= '0;
         idle_count <= '0;
         array_standby <= 1'b0;
      end
      else
      begin
         bus_q <= arr_bus;
         if (arr_bus != bus_q || power_mode_reg0[space_decode_pkg::fast_mode_bit])
            idle_count <= '0;
         else if (idle_count != idle_max)
            idle_count <= idle_count + 1'b1;
         array_standby <= ~power_mode_reg0[space_decode_pkg::fast_mode_bit]
                        & (arr_bus == bus_q) & (idle_count == idle_max); // R20
      end
   end
endmodule // memory_space_decode
`default_nettype wire

// ===== hw/space_decode_pkg.sv
// shared constants and carriers for the memory space decode block
package space_decode_pkg;
   localparam int addr_width = 16;
   localparam int ext_addr_width = 20;
   localparam int page_width = 8;
   localparam int primary_sectors = 8;
   localparam int secondary_sectors = 4;
   localparam int sector_terms = 3;
   localparam int ram_terms = 2;
   localparam int array_inputs = 73;
   localparam int general_terms_max = 137;
   localparam int ext_selects = 3;
   localparam int periph_selects = 2;
   localparam int block_blocks = 5;
   localparam logic [7:0] page_offset = 8'h00_E0;
   localparam logic [7:0] space_map_offset = 8'h00_C2;
   localparam logic [7:0] power_mode0_offset = 8'h00_B0;
   localparam logic [7:0] power_mode2_offset = 8'h00_B4;
   localparam logic [7:0] space_map_init = 8'h00_0C;
   localparam logic [7:0] page_init = 8'h00_00;
   localparam logic [7:0] power_mode0_init = 8'h00_00;
   localparam logic [7:0] power_mode2_init = 8'h00_00;
   localparam int map_sram_code = 0;
   localparam int map_secondary_code = 1;
   localparam int map_primary_code = 2;
   localparam int map_secondary_data = 3;
   localparam int map_primary_data = 4;
   localparam int map_pio_enable = 7;
   localparam int fast_mode_bit = 3;
   localparam int standby_time_ns = 70;
   localparam int clock_period_ns = 4;
   localparam int standby_cycles = standby_time_ns / clock_period_ns;
   typedef struct packed {
      logic [ext_addr_width-1:0] addr;
      logic program_strobe;
      logic bus_control_1;
      logic write_strobe;
      logic ext_addr_mode;
   } host_bus_s;
   typedef struct packed {
      logic [primary_sectors-1:0] primary_sector_sel;
      logic [secondary_sectors-1:0] secondary_sector_sel;
      logic ram_select;
      logic config_reg_select;
      logic test_port_select;
      logic [periph_selects-1:0] periph_select;
   } selects_s;
   typedef struct packed {
      logic [primary_sectors-1:0] primary_oe;
      logic [secondary_sectors-1:0] secondary_oe;
      logic ram_oe;
      logic config_oe;
      logic [periph_selects-1:0] periph_oe;
   } enables_s;
endpackage

// ===== hw/product_term_or.sv
// sum of a small number of programmable product terms over the shared input bus
`timescale 1ns/1ps
`default_nettype none
module product_term_or #(
   parameter int inputs = 73,
   parameter int terms = 3
) (
   input wire logic [inputs-1:0] bus,
   input wire logic [terms*inputs-1:0] care,
   input wire logic [terms*inputs-1:0] value,
   input wire logic [terms-1:0] term_used,
   output logic hit
);
   logic [terms-1:0] term_hit;
   always_comb
   begin
      for (int t = 0; t < terms; t++)
      begin
         term_hit[t] = term_used[t] &
            ~|((bus ^ value[t*inputs +: inputs]) & care[t*inputs +: inputs]);
      end
      hit = |term_hit;
   end
endmodule // product_term_or
`default_nettype wire

// ===== bench/space_decode_asserts.sv
// port assertions for the memory space decode block
`timescale 1ns/1ps
`default_nettype none
module space_checker (
   input wire logic clock,
   input wire logic rstn,
   input wire space_decode_pkg::host_bus_s host_bus,
   input wire logic [7:0] data_in,
   input wire space_decode_pkg::selects_s selects,
   input wire space_decode_pkg::enables_s enables,
   input wire logic [7:0] page_bits,
   input wire logic [7:0] space_map_reg
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   sequence s_cfg_wr(logic [7:0] off);
      $rose(host_bus.write_strobe) && host_bus.addr[15:0] == {8'hFF, off};
   endsequence
   sequence s_fetch_seen;
      $past(host_bus.program_strobe, 3);
   endsequence
   sequence s_read_seen;
      $past(host_bus.bus_control_1, 3);
   endsequence
   a_page_load:
      assert property (s_cfg_wr(space_decode_pkg::page_offset)
         |-> ##3 page_bits == $past(data_in, 3)) else $error("page load wrong");
   a_map_load:
      assert property (s_cfg_wr(space_decode_pkg::space_map_offset)
         |-> ##3 space_map_reg == ($past(data_in, 3) & 8'h9F)) else $error("map load wrong");
   a_map_spare:
      assert property (space_map_reg[6:5] == 2'b00) else $error("map spare bits set");
   a_primary_gate:
      assert property (|enables.primary_oe |-> (s_fetch_seen and space_map_reg[2])
         or (s_read_seen and space_map_reg[4])) else $error("primary enable not permitted");
   a_secondary_gate:
      assert property (|enables.secondary_oe |-> (s_fetch_seen and space_map_reg[1])
         or (s_read_seen and space_map_reg[3])) else $error("secondary enable not permitted");
   a_ram_needs_sel:
      assert property (enables.ram_oe |-> selects.ram_select) else $error("ram without select");
   a_sec_over_pri:
      assert property (|selects.secondary_sector_sel |-> enables.primary_oe == 8'h00)
         else $error("primary beat secondary");
   a_ram_over_flash:
      assert property (selects.ram_select |-> !(|{enables.primary_oe, enables.secondary_oe}))
         else $error("flash beat ram");
   a_single_oe:
      assert property ($onehot0(enables)) else $error("two enables at once");
endmodule // space_checker
bind memory_space_decode space_checker chk_u (.clock(clock), .rstn(rstn), .host_bus(host_bus),
   .data_in(data_in), .selects(selects), .enables(enables), .page_bits(page_bits),
   .space_map_reg(space_map_reg));
`default_nettype wire

// ===== bench/mcu_host_model.sv
// host processor model with separate fetch and read strobes
`timescale 1ns/1ps
`default_nettype none
module mcu_host (
   input wire logic clock,
   input wire logic [7:0] data_out,
   output var space_decode_pkg::host_bus_s host_bus,
   output logic [7:0] data_in
);
   initial
   begin
      host_bus = '0;
      data_in = 8'hA5;
   end
   // strobe held four edges so the two-flop sync never misses it
   task automatic cfg_wr(input logic [7:0] off, input logic [7:0] d);
      @(posedge clock);
      host_bus.addr <= {4'h0, 8'hFF, off};
      host_bus.ext_addr_mode <= 1'b0;
      data_in <= d;
      host_bus.write_strobe <= 1'b1;
      repeat (4) @(posedge clock);
      host_bus.write_strobe <= 1'b0;
      // released data bus shows the inverse, not a stale copy
      data_in <= ~d;
      repeat (3) @(posedge clock);
   endtask
   task automatic rel();
      @(posedge clock);
      host_bus.program_strobe <= 1'b0;
      host_bus.bus_control_1 <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   // fetch strobe for program space, read strobe for data space
   task automatic acc(input logic [19:0] a, input logic x, input logic f, input logic r);
      @(posedge clock);
      host_bus.addr <= a;
      host_bus.ext_addr_mode <= x;
      host_bus.program_strobe <= f;
      host_bus.bus_control_1 <= r;
      repeat (5) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic cfg_rd(input logic [7:0] off, output logic [7:0] d);
      acc({4'h0, 8'hFF, off}, 1'b0, 1'b0, 1'b1);
      d = data_out;
      rel();
   endtask
endmodule // mcu_host
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the memory space decode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   space_decode_pkg::host_bus_s host_bus;
   space_decode_pkg::selects_s selects;
   space_decode_pkg::enables_s enables;
   logic [7:0] data_in, data_out, page_bits, space_map_reg, general_page_bits;
   logic [23:0] input_cell = '0;
   logic [2:0] port_d_in = '0;
   logic [7:0] fb1 = '0, fb2 = '0, gmask = '0;
   logic [3503:0] dec_care = '0, dec_value = '0;
   logic [47:0] dec_used = '0;
   logic [656:0] ecs_care = '0, ecs_value = '0;
   logic [8:0] ecs_used = 9'h04B;
   logic [2:0] ext_chip_sel;
   logic data_out_valid, array_standby;
   logic [15:0] seed = 16'hBB9F;
   logic [7:0] maps [7] = '{8'h0C, 8'h14, 8'h1F, 8'h00, 8'h0B, 8'h05, 8'h00};
   logic [15:0] addrs [10] = '{16'h1100, 16'h3100, 16'h5100, 16'h7100, 16'h9100,
      16'hB100, 16'hD100, 16'hF100, 16'h8100, 16'h4100};
   int failures = 0;
   int tests_run = 0;
   wire logic [12:0] oe_seen = {enables.primary_oe, enables.secondary_oe, enables.ram_oe};
   always #2 clock = ~clock;
   mcu_host host_u (.clock(clock), .data_out(data_out), .host_bus(host_bus), .data_in(data_in));
   memory_space_decode dut_u (.clock(clock), .rstn(rstn), .host_bus(host_bus), .data_in(data_in),
      .reset_input(1'b0), .power_down_input(1'b0), .input_cell(input_cell),
      .port_d_in(port_d_in), .cell_group1_feedback(fb1), .cell_group2_feedback(fb2),
      .secondary_busy(1'b0), .dec_care(dec_care), .dec_value(dec_value), .dec_used(dec_used),
      .ecs_care(ecs_care), .ecs_value(ecs_value), .ecs_used(ecs_used),
      .general_page_mask(gmask), .data_out(data_out), .data_out_valid(data_out_valid),
      .selects(selects), .enables(enables), .ext_chip_sel(ext_chip_sel),
      .page_bits(page_bits), .space_map_reg(space_map_reg),
      .general_page_bits(general_page_bits), .array_standby(array_standby));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // priority ram, config, peripheral, secondary, primary; then the strobe gate
   function automatic logic [12:0] exp_mem(input int a, input int f, input int r, input int m,
      input int pg);
      logic [12:0] e;
      e = '0;
      if ((a >> 11) == 16 || (a >> 12) == 4)
         e[0] = (r | f & m) & 1;
      else if ((a >> 8) == 255 || ((a >> 9) == 80 && (m >> 7 & 1) == 1))
         e = '0;
      else if ((pg & 1) == 1)
         e[1 + (a >> 14 & 3)] = (f & m >> 1 | r & m >> 3) & 1;
      else
         e[5 + (a >> 13 & 7)] = (f & m >> 2 | r & m >> 4) & 1;
      return e;
   endfunction
   task automatic chk_sel(input string n, input logic [12:0] e, input logic [12:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      chk_sel(n, {5'h00, e}, {5'h00, g});
   endtask
   task automatic set_dec(input int s, input int t, input logic [72:0] c, input logic [72:0] v);
      dec_care[(s * 3 + t) * 73 +: 73] = c;
      dec_value[(s * 3 + t) * 73 +: 73] = v;
      dec_used[s * 3 + t] = 1'b1;
   endtask
   task automatic final_report();
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #160000;
      failures++;
      final_report();
   end
   initial
   begin
      logic [7:0] v;
      for (int k = 0; k < 8; k++)
         set_dec(k, 0, 73'hE000, 73'(k) << 13);
      for (int j = 0; j < 4; j++)
         set_dec(8 + j, 0, 73'h1_0000_0000_C000, 73'h1_0000_0000_0000 | (73'(j) << 14));
      set_dec(12, 0, 73'hF800, 73'h8000);
      set_dec(12, 1, 73'hF000, 73'h4000);
      set_dec(13, 0, 73'hFFFF, 73'h1234);
      set_dec(14, 0, 73'hFF00, 73'hA000);
      set_dec(15, 0, 73'hFF00, 73'hA100);
      ecs_care[21] = 1'b1;
      ecs_value[21] = 1'b1;
      ecs_care[91] = 1'b1;
      ecs_value[91] = 1'b1;
      ecs_care[265] = 1'b1;
      ecs_value[265] = 1'b1;
      ecs_care[497] = 1'b1;
      ecs_value[497] = 1'b1;
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk_reg("map reset", 8'h0C, space_map_reg);
      chk_reg("page reset", 8'h00, page_bits);
      seed = lfsr(seed);
      @(posedge clock);
      gmask <= seed[15:8];
      host_u.cfg_wr(8'hE0, seed[7:0]);
      host_u.cfg_rd(8'hE0, v);
      chk_reg("page read", seed[7:0], v);
      chk_reg("general page", seed[7:0] & seed[15:8], general_page_bits);
      host_u.cfg_wr(8'hC2, seed[15:8]);
      host_u.cfg_rd(8'hC2, v);
      chk_reg("map read", seed[15:8] & 8'h9F, v);
      host_u.acc(20'h0_FF55, 1'b0, 1'b0, 1'b1);
      chk_reg("unmapped read", 8'h00, data_out);
      chk_sel("config read", 13'h7,
         13'({data_out_valid, selects.config_reg_select, enables.config_oe}));
      host_u.rel();
      seed = lfsr(seed);
      maps[6] = seed[7:0] & 8'h1F;
      foreach (maps[i])
      begin
         host_u.cfg_wr(8'hC2, maps[i]);
         for (int pg = 0; pg < 2; pg++)
         begin
            host_u.cfg_wr(8'hE0, 8'(pg));
            foreach (addrs[j])
               for (int f = 0; f < 2; f++)
               begin
                  host_u.acc({4'h0, addrs[j]}, 1'b0, f[0], !f[0]);
                  chk_sel("enables", exp_mem(addrs[j], f, 1 - f, maps[i], pg), oe_seen);
                  host_u.rel();
               end
         end
      end
      for (int i = 0; i < 3; i++)
      begin
         host_u.acc(i == 0 ? 20'h1_2340 : 20'h0_1234, 1'(i < 2), 1'b0, 1'b1);
         chk_sel("test port", 13'(i != 1), 13'(selects.test_port_select));
         host_u.rel();
      end
      host_u.cfg_wr(8'hC2, 8'h9C);
      for (int i = 0; i < 2; i++)
      begin
         host_u.acc({4'h0, 8'hA0 | 8'(i), 8'h10}, 1'b0, 1'b0, 1'b1);
         chk_sel("periph", 13'(1 << i), 13'(selects.periph_select));
         chk_sel("periph oe", 13'(1 << i), 13'(enables.periph_oe));
         chk_sel("periph wins", exp_mem(16'hA010 | (i << 8), 0, 1, 8'h9C, 1), oe_seen);
         host_u.rel();
      end
      host_u.acc(20'h0_1000, 1'b0, 1'b1, 1'b0);
      chk_sel("fetch term", 13'h1, 13'(ext_chip_sel));
      host_u.rel();
      host_u.cfg_wr(8'hB4, 8'hFF);
      host_u.cfg_rd(8'hB4, v);
      chk_reg("power2 read", 8'h1F, v);
      host_u.acc(20'h0_1000, 1'b0, 1'b1, 1'b0);
      chk_sel("fetch blocked", 13'h0, 13'(ext_chip_sel));
      host_u.rel();
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         @(posedge clock);
         input_cell <= {seed, seed[7:0]};
         port_d_in <= seed[10:8];
         fb1 <= seed[15:8];
         repeat (5) @(posedge clock);
         @(negedge clock);
         chk_sel("ext selects", 13'({seed[11], seed[9], seed[0]}), 13'(ext_chip_sel));
      end
      repeat (30) @(posedge clock);
      @(negedge clock);
      chk_sel("standby", 13'h1, 13'(array_standby));
      host_u.cfg_wr(8'hB0, 8'h08);
      repeat (30) @(posedge clock);
      @(negedge clock);
      chk_sel("fast mode", 13'h0, 13'(array_standby));
      final_report();
   end
endmodule // tb_top
`default_nettype wire
